// *** hw/bdm_defines.svh ***
`ifndef BDM_DEFINES_SVH
`define BDM_DEFINES_SVH

// Address space shape
`define BDM_ADDR_W 12
`define BDM_OFFS_W 8
`define BDM_BANK_W 4
`define BDM_NUM_BANKS 16
`define BDM_BANK_BYTES 256

// Implemented general purpose bank and its base
`define BDM_GPR_BANK 4'h0
`define BDM_GPR_BASE 12'h000

// Access Bank map
`define BDM_ACC_SPLIT 8'h80
`define BDM_ACC_LO_BASE 12'h000
`define BDM_ACC_HI_BASE 12'hF00

// Special function register window in the top half of the last bank
`define BDM_SFR_BASE 12'hF80
`define BDM_SFR_TOP 12'hFFF
`define BDM_SFR_IDX_W 7

// Bank select register location and layout
`define BDM_BSEL_ADDR 12'hFE0
`define BDM_BSEL_RESET 4'h0
`define BDM_BSEL_UPPER 4'h0

// Value of any unimplemented location
`define BDM_ZERO_BYTE 8'h00

`endif

// *** hw/bdm_pkg.sv ***
`default_nettype none
package bdm_pkg;
   typedef logic [11:0] bdm_addr_t;
   typedef logic [7:0] bdm_byte_t;
   typedef enum logic [0:0] {
      BDM_IDLE,
      BDM_MOVE_WR
   } bdm_state_t;
endpackage : bdm_pkg
`default_nettype wire

// *** hw/bdm_data_mem.sv ***
// Behaviour
// RL1: Every data location has a 12-bit address
// RL2: Sixteen banks of 256 bytes, bank on top
// RL3: Only one data RAM bank is built
// RL4: Unimplemented locations always read as zero
// RL5: Banked address is bank select over operand
// RL6: Bank select upper nibble reads zero, unwritable
// RL7: Load-bank-literal writes literal into bank select
// RL8: Unimplemented bank writes dropped, reads zero
// RL9: Status flags update even for unimplemented targets
// RL10: Full-address move ignores bank select entirely
// RL11: Other accesses use bank select or access map
// RL12: Access map: bank 0 low, bank 15 high
// RL13: Access bit one selects banked addressing
// RL14: Access bit zero forces access map
// RL15: Access map access completes in one cycle
// RL16: Extended set uses another map, not here
// RL17: General registers from 000h, never reset
// RL18: Special registers F80h-FFFh, unused read zero
// RL19: Core reads phase two, writes phase four
// RL20: Access map base 000h below 80h, else F00h
`timescale 1ns/1ps
`default_nettype none
`include "bdm_defines.svh"

module bdm_data_mem #(
   parameter int GPR_BYTES = `BDM_BANK_BYTES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Configuration
   input wire logic ext_set_enable,
   // Short-address access from the execution core
   input wire logic acc_rd_en,
   input wire logic acc_wr_en,
   input wire logic acc_sel,
   input wire bdm_pkg::bdm_byte_t acc_offset,
   input wire bdm_pkg::bdm_byte_t acc_wdata,
   // Load bank literal
   input wire logic load_bank_literal_en,
   input wire bdm_pkg::bdm_byte_t load_bank_literal,
   // Full address move
   input wire logic move_full_address_en,
   input wire bdm_pkg::bdm_addr_t move_src,
   input wire bdm_pkg::bdm_addr_t move_dst,
   // Answer to the core
   output logic busy,
   output bdm_pkg::bdm_byte_t rd_data,
   output logic rd_valid,
   output logic status_upd,
   output logic unimpl_hit,
   output logic ext_map_req,
   output bdm_pkg::bdm_byte_t bank_select,
   // Special function register port
   output logic sfr_rd_strobe,
   output logic [`BDM_SFR_IDX_W-1:0] sfr_rd_index,
   input wire bdm_pkg::bdm_byte_t sfr_rd_data,
   input wire logic sfr_rd_ack,
   output logic sfr_wr_strobe,
   output logic [`BDM_SFR_IDX_W-1:0] sfr_wr_index,
   output bdm_pkg::bdm_byte_t sfr_wr_data
);
   import bdm_pkg::*;

   localparam logic [8:0] GPR_LIM = 9'(GPR_BYTES);

   // Access Bank or banked address from an 8-bit operand
   function automatic bdm_addr_t eff_addr(input logic sel, input logic [3:0] bsel,
                                          input bdm_byte_t offs);
      bdm_addr_t a;
      a = `BDM_ACC_LO_BASE;
      if (sel) begin
         a = {bsel, offs}; // [RL5] [RL13]
      end else if (offs < `BDM_ACC_SPLIT) begin
         a = `BDM_ACC_LO_BASE | {4'h0, offs}; // [RL12] [RL20] [RL14]
      end else begin
         a = `BDM_ACC_HI_BASE | {4'h0, offs}; // [RL12] [RL20] [RL14]
      end
      return a;
   endfunction : eff_addr

   // Only the general purpose bank holds RAM
   function automatic logic is_gpr(input bdm_addr_t a);
      return (a[11:8] == `BDM_GPR_BANK) && ({1'b0, a[7:0]} < GPR_LIM); // [RL3] [RL2]
   endfunction : is_gpr

   function automatic logic is_sfr(input bdm_addr_t a);
      return (a >= `BDM_SFR_BASE) && (a <= `BDM_SFR_TOP); // [RL18]
   endfunction : is_sfr

   // General purpose storage: deliberately without reset so contents survive
   bdm_byte_t ram [0:GPR_BYTES-1];

   bdm_state_t state_reg, state_next;
   logic [3:0] bsel_reg, bsel_next;
   bdm_addr_t dst_reg, dst_next;
   bdm_byte_t rd_data_reg, rd_data_next;
   logic rd_valid_reg, rd_valid_next;
   logic status_reg, status_next;
   logic unimpl_reg, unimpl_next;
   logic ext_reg, ext_next;
   logic sfr_wr_reg, sfr_wr_next;
   logic [`BDM_SFR_IDX_W-1:0] sfr_widx_reg, sfr_widx_next;
   bdm_byte_t sfr_wdata_reg, sfr_wdata_next;

   logic idle;
   logic ext_block;
   logic acc_go;
   logic move_go;
   logic rd_go;
   logic wr_go;
   bdm_addr_t acc_addr;
   bdm_addr_t rd_addr;
   bdm_addr_t wr_addr;
   bdm_byte_t wr_byte;
   bdm_byte_t rd_byte;
   logic ram_we;
   logic [7:0] ram_idx;

   // Request steering; the full move takes precedence over short accesses
   always_comb begin
      idle = (state_reg == BDM_IDLE);
      ext_block = ext_set_enable && !acc_sel; // [RL16]
      move_go = idle && move_full_address_en;
      acc_go = idle && !move_full_address_en && (acc_rd_en || acc_wr_en);
      acc_addr = eff_addr(acc_sel, bsel_reg, acc_offset); // [RL11] [RL1]
      rd_go = move_go || (acc_go && acc_rd_en && !ext_block);
      rd_addr = move_go ? move_src : acc_addr; // [RL10]
      wr_go = (state_reg == BDM_MOVE_WR) || (acc_go && acc_wr_en && !ext_block);
      wr_addr = (state_reg == BDM_MOVE_WR) ? dst_reg : acc_addr; // [RL10]
      wr_byte = (state_reg == BDM_MOVE_WR) ? rd_data_reg : acc_wdata;
      busy = !idle;
   end

   // Read multiplexer; anything not backed by storage returns zero
   always_comb begin
      rd_byte = `BDM_ZERO_BYTE; // [RL4] [RL8]
      sfr_rd_strobe = 1'b0;
      sfr_rd_index = rd_addr[`BDM_SFR_IDX_W-1:0];
      if (rd_go) begin
         if (is_gpr(rd_addr)) begin
            rd_byte = ram[rd_addr[7:0]];
         end else if (rd_addr == `BDM_BSEL_ADDR) begin
            rd_byte = {`BDM_BSEL_UPPER, bsel_reg}; // [RL6]
         end else if (is_sfr(rd_addr)) begin
            sfr_rd_strobe = 1'b1;
            rd_byte = sfr_rd_ack ? sfr_rd_data : `BDM_ZERO_BYTE; // [RL18]
         end
      end
   end

   // Storage write decode
   always_comb begin
      ram_we = wr_go && is_gpr(wr_addr); // [RL8] [RL17]
      ram_idx = wr_addr[7:0];
   end

   // Control, bank select and answer registers
   always_comb begin
      state_next = state_reg;
      bsel_next = bsel_reg;
      dst_next = dst_reg;
      rd_data_next = rd_data_reg;
      rd_valid_next = 1'b0;
      status_next = 1'b0;
      unimpl_next = 1'b0;
      ext_next = 1'b0;
      sfr_wr_next = 1'b0;
      sfr_widx_next = sfr_widx_reg;
      sfr_wdata_next = sfr_wdata_reg;
      case (state_reg)
         BDM_IDLE: begin
            if (move_go) begin
               dst_next = move_dst;
               state_next = BDM_MOVE_WR;
            end
         end
         BDM_MOVE_WR: begin
            state_next = BDM_IDLE;
         end
         default: begin
            state_next = BDM_IDLE;
         end
      endcase
      if (rd_go) begin
         rd_data_next = rd_byte; // [RL15]
      end
      if (acc_go) begin
         rd_valid_next = acc_rd_en;
         status_next = 1'b1; // [RL9]
         ext_next = ext_block;
      end
      if ((rd_go && !is_gpr(rd_addr) && !is_sfr(rd_addr)) ||
          (wr_go && !is_gpr(wr_addr) && !is_sfr(wr_addr))) begin
         unimpl_next = 1'b1; // [RL8]
      end
      if (wr_go && is_sfr(wr_addr)) begin
         if (wr_addr == `BDM_BSEL_ADDR) begin
            bsel_next = wr_byte[3:0]; // [RL6]
         end else begin
            sfr_wr_next = 1'b1;
            sfr_widx_next = wr_addr[`BDM_SFR_IDX_W-1:0];
            sfr_wdata_next = wr_byte;
         end
      end
      // Literal load wins over a data write to the same register
      if (load_bank_literal_en) begin
         bsel_next = load_bank_literal[3:0]; // [RL7]
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= BDM_IDLE;
         bsel_reg <= `BDM_BSEL_RESET;
         dst_reg <= `BDM_GPR_BASE;
         rd_data_reg <= `BDM_ZERO_BYTE;
         rd_valid_reg <= 1'b0;
         status_reg <= 1'b0;
         unimpl_reg <= 1'b0;
         ext_reg <= 1'b0;
         sfr_wr_reg <= 1'b0;
         sfr_widx_reg <= '0;
         sfr_wdata_reg <= `BDM_ZERO_BYTE;
      end else begin
         state_reg <= state_next;
         bsel_reg <= bsel_next;
         dst_reg <= dst_next;
         rd_data_reg <= rd_data_next;
         rd_valid_reg <= rd_valid_next;
         status_reg <= status_next;
         unimpl_reg <= unimpl_next;
         ext_reg <= ext_next;
         sfr_wr_reg <= sfr_wr_next;
         sfr_widx_reg <= sfr_widx_next;
         sfr_wdata_reg <= sfr_wdata_next;
      end
   end

   // No reset branch: neither power-on nor later resets touch this storage
   always_ff @(posedge core_clk) begin
      if (ram_we) begin
         ram[ram_idx] <= wr_byte; // [RL17]
      end
   end

   assign rd_data = rd_data_reg;
   assign rd_valid = rd_valid_reg;
   assign status_upd = status_reg;
   assign unimpl_hit = unimpl_reg;
   assign ext_map_req = ext_reg;
   assign bank_select = {`BDM_BSEL_UPPER, bsel_reg}; // [RL6]
   assign sfr_wr_strobe = sfr_wr_reg;
   assign sfr_wr_index = sfr_widx_reg;
   assign sfr_wr_data = sfr_wdata_reg;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   sequence move_start_s;
      idle && move_full_address_en;
   endsequence

   sequence move_write_s;
      (state_reg == BDM_MOVE_WR) && wr_go;
   endsequence

   // Data write to the bank select keeps only the low nibble; upper reads zero
   bsel_write_a: assert property ( // [RL6]
      (wr_go && wr_addr == `BDM_BSEL_ADDR && !load_bank_literal_en)
      |=> bank_select == ($past(wr_byte) & 8'h0F))
      else $error("bank select write wrong");

   literal_load_a: assert property ( // [RL7]
      load_bank_literal_en |=> bank_select == ($past(load_bank_literal) & 8'h0F))
      else $error("literal not loaded into bank select");

   unimpl_zero_a: assert property ( // [RL4]
      (acc_go && acc_rd_en && !ext_block && !is_gpr(acc_addr) && !is_sfr(acc_addr))
      |=> rd_valid && rd_data == 8'h00 && unimpl_hit)
      else $error("unimplemented read not zero");

   status_always_a: assert property ( // [RL9]
      acc_go |=> status_upd ##1 !status_upd || $past(acc_go))
      else $error("status update missing");

   access_map_a: assert property ( // [RL14]
      (acc_go && !acc_sel) |->
      acc_addr == ((acc_offset < 8'h80) ? {4'h0, acc_offset} : {4'hF, acc_offset}))
      else $error("access bank map wrong");

   banked_addr_a: assert property ( // [RL13]
      (acc_go && acc_sel) |-> acc_addr == {bsel_reg, acc_offset})
      else $error("banked address wrong");

   move_full_a: assert property ( // [RL10]
      move_start_s |-> rd_addr == move_src ##1 move_write_s ##0 wr_addr == $past(move_dst)
      ##1 idle)
      else $error("full address move sequence wrong");

   gpr_store_a: assert property ( // [RL17]
      ram_we |=> ram[$past(ram_idx)] == $past(wr_byte))
      else $error("general register write lost");

   one_cycle_a: assert property ( // [RL15]
      (acc_go && acc_rd_en) |=> rd_valid ##1 !rd_valid || $past(acc_go && acc_rd_en))
      else $error("read answer not in one cycle");

   unimpl_wr_a: assert property ( // [RL8]
      (wr_go && !is_gpr(wr_addr) && !is_sfr(wr_addr)) |-> !ram_we ##1 unimpl_hit)
      else $error("unimplemented write not dropped");

endmodule : bdm_data_mem

`default_nettype wire

// *** verification/bdm_sfr_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bdm_sfr_model (
   // Clock
   input wire logic core_clk,
   // Request from the block; ack_en from the bench
   input wire logic sfr_rd_strobe,
   input wire logic [6:0] sfr_rd_index,
   input wire logic ack_en,
   // Answer
   output logic sfr_rd_ack,
   output bdm_pkg::bdm_byte_t sfr_rd_data
);
   import bdm_pkg::*;
   bdm_byte_t idle_reg = 8'h3C;
   // Idle bus toggles so a stale byte is never taken for an answer
   always @(posedge core_clk) begin
      idle_reg <= ~idle_reg;
   end
   assign sfr_rd_ack = sfr_rd_strobe & ack_en;
   assign sfr_rd_data = sfr_rd_ack ? ({1'b1, sfr_rd_index} ^ 8'h5A) : idle_reg;
endmodule : bdm_sfr_model
`default_nettype wire

// *** verification/banked_data_memory_addressing_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module banked_data_memory_addressing_bench;
   import bdm_pkg::*;
   logic core_clk, arst_n, ext_set_enable, acc_rd_en, acc_wr_en, acc_sel, ack_en;
   logic load_bank_literal_en, move_full_address_en, busy, rd_valid, status_upd;
   logic unimpl_hit, ext_map_req, sfr_rd_strobe, sfr_rd_ack, sfr_wr_strobe;
   bdm_byte_t acc_offset, acc_wdata, load_bank_literal, rd_data, bank_select;
   bdm_byte_t sfr_rd_data, sfr_wr_data;
   bdm_addr_t move_src, move_dst;
   logic [6:0] sfr_rd_index, sfr_wr_index;
   bdm_byte_t mem [0:255];
   bdm_byte_t off, wd;
   int errors, checked;

   bdm_data_mem u_bdm_data_mem (.core_clk(core_clk), .arst_n(arst_n),
      .ext_set_enable(ext_set_enable), .acc_rd_en(acc_rd_en), .acc_wr_en(acc_wr_en),
      .acc_sel(acc_sel), .acc_offset(acc_offset), .acc_wdata(acc_wdata),
      .load_bank_literal_en(load_bank_literal_en), .load_bank_literal(load_bank_literal),
      .move_full_address_en(move_full_address_en), .move_src(move_src), .move_dst(move_dst),
      .busy(busy), .rd_data(rd_data), .rd_valid(rd_valid), .status_upd(status_upd),
      .unimpl_hit(unimpl_hit), .ext_map_req(ext_map_req), .bank_select(bank_select),
      .sfr_rd_strobe(sfr_rd_strobe), .sfr_rd_index(sfr_rd_index), .sfr_rd_data(sfr_rd_data),
      .sfr_rd_ack(sfr_rd_ack), .sfr_wr_strobe(sfr_wr_strobe), .sfr_wr_index(sfr_wr_index),
      .sfr_wr_data(sfr_wr_data));
   bdm_sfr_model u_bdm_sfr_model (.core_clk(core_clk), .sfr_rd_strobe(sfr_rd_strobe),
      .sfr_rd_index(sfr_rd_index), .ack_en(ack_en), .sfr_rd_ack(sfr_rd_ack),
      .sfr_rd_data(sfr_rd_data));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic final_report;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report

   task automatic chk(input string what, input bdm_byte_t exp, input bdm_byte_t got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Called at a falling edge; request stays driven after the cycle until the next call changes it, answer checked a cycle on
   task automatic acc(input logic rd, input logic wr, input logic sel, input bdm_byte_t o,
                      input bdm_byte_t d);
      acc_rd_en = rd;
      acc_wr_en = wr;
      acc_sel = sel;
      acc_offset = o;
      acc_wdata = d;
      @(negedge core_clk);
   endtask : acc

   task automatic lbl(input bdm_byte_t v);
      load_bank_literal = v;
      load_bank_literal_en = 1'b1;
      @(negedge core_clk);
      load_bank_literal_en = 1'b0;
      @(negedge core_clk);
   endtask : lbl

   function automatic bdm_byte_t exp_hi(bdm_byte_t o, logic ack, bdm_byte_t b);
      if (o == 8'hE0) return b;
      return ack ? ({1'b1, o[6:0]} ^ 8'h5A) : 8'h00;
   endfunction : exp_hi

   initial begin
      repeat (5000) @(posedge core_clk);
      errors++;
      final_report();
   end

   initial begin
      {arst_n, ext_set_enable, acc_rd_en, acc_wr_en, acc_sel, ack_en} = 6'h00;
      {load_bank_literal_en, move_full_address_en} = 2'h0;
      {acc_offset, acc_wdata, load_bank_literal} = 24'h000000;
      {move_src, move_dst} = 24'h000000;
      errors = 0;
      checked = 0;
      void'($urandom(14521));
      repeat (16) @(negedge core_clk);
      arst_n = 1'b1;
      @(negedge core_clk);
      lbl(8'hA5);
      chk("bank_select", 8'h05, bank_select);
      acc(1'b1, 1'b0, 1'b0, 8'hE0, 8'h00);
      chk("bank_select read", 8'h05, rd_data);
      lbl(8'h00);
      for (int i = 0; i < 40; i++) begin
         off = 8'($urandom_range(0, 127));
         wd = 8'($urandom);
         acc(1'b0, 1'b1, 1'b0, off, wd);
         mem[off] = wd;
         chk("status_upd", 8'h01, {7'h00, status_upd});
         acc(1'b1, 1'b0, i[0], off, 8'h00);
         chk("rd_data", mem[off], rd_data);
         chk("rd_valid", 8'h01, {7'h00, rd_valid});
      end
      acc(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
      lbl(8'h05);
      acc(1'b0, 1'b1, 1'b1, off, ~wd);
      chk("unimpl_hit", 8'h01, {7'h00, unimpl_hit});
      chk("status_upd", 8'h01, {7'h00, status_upd});
      acc(1'b1, 1'b0, 1'b1, off, 8'h00);
      chk("unimpl read", 8'h00, rd_data);
      acc(1'b1, 1'b0, 1'b0, off, 8'h00);
      chk("bank0 kept", wd, rd_data);
      for (int i = 0; i < 12; i++) begin
         off = 8'h80 | 8'($urandom_range(0, 127));
         if (i == 0) off = 8'hE0;
         ack_en = 1'($urandom);
         acc(1'b1, 1'b0, 1'b0, off, 8'h00);
         chk("sfr read", exp_hi(off, ack_en, 8'h05), rd_data);
      end
      acc(1'b0, 1'b1, 1'b0, 8'hE0, 8'hF9);
      acc(1'b0, 1'b1, 1'b0, 8'h9B, 8'hC3);
      chk("sfr_wr_strobe", 8'h01, {7'h00, sfr_wr_strobe});
      chk("sfr_wr_index", 8'h1B, {1'b0, sfr_wr_index});
      chk("sfr_wr_data", 8'hC3, sfr_wr_data);
      acc(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
      chk("bank_select", 8'h09, bank_select);
      chk("sfr_wr_strobe", 8'h00, {7'h00, sfr_wr_strobe});
      move_src = 12'h000;
      move_dst = 12'h0F0;
      acc(1'b0, 1'b1, 1'b0, 8'h00, 8'h6C);
      acc(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
      move_full_address_en = 1'b1;
      @(negedge core_clk);
      move_full_address_en = 1'b0;
      chk("busy", 8'h01, {7'h00, busy});
      @(negedge core_clk);
      acc(1'b1, 1'b0, 1'b1, 8'hF0, 8'h00);
      chk("bank9 read", 8'h00, rd_data);
      lbl(8'h00);
      acc(1'b1, 1'b0, 1'b1, 8'hF0, 8'h00);
      chk("move dest", 8'h6C, rd_data);
      ext_set_enable = 1'b1;
      acc(1'b1, 1'b0, 1'b0, 8'h10, 8'h00);
      chk("ext_map_req", 8'h01, {7'h00, ext_map_req});
      chk("ext rd_valid", 8'h01, {7'h00, rd_valid});
      chk("ext status_upd", 8'h01, {7'h00, status_upd});
      ext_set_enable = 1'b0;
      acc(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
      arst_n = 1'b0;
      @(negedge core_clk);
      arst_n = 1'b1;
      @(negedge core_clk);
      chk("bank after reset", 8'h00, bank_select);
      acc(1'b1, 1'b0, 1'b0, 8'h00, 8'h00);
      chk("gpr kept", 8'h6C, rd_data);
      final_report();
   end
endmodule : banked_data_memory_addressing_bench
`default_nettype wire
